// [src/dsf_buf2.sv]
`timescale 1ns/100ps
`default_nettype none
module dsf_buf2 #(
   parameter int WIDTH = dsf_pkg::RES_W
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   import dsf_pkg::*;

   typedef struct packed {
      logic head_v;
      logic [WIDTH-1:0] head_d;
      logic skid_v;
      logic [WIDTH-1:0] skid_d;
   } dsf_buf_t;

   dsf_buf_t st_q, st_d;

   // ==========================================================
   // Two entries: a head that drives the output and a skid slot.
   always_comb begin
      st_d = st_q;
      if (st_q.head_v && out_ready) begin
         st_d.head_v = 1'b0;
      end
      if (!st_d.head_v && st_q.skid_v) begin
         st_d.head_v = 1'b1;
         st_d.head_d = st_q.skid_d;
         st_d.skid_v = 1'b0;
      end
      // Ready comes from a flop, so the skid slot absorbs the word taken in the stall cycle.
      if (in_valid && !st_q.skid_v) begin
         if (!st_d.head_v) begin
            st_d.head_v = 1'b1;
            st_d.head_d = in_data;
         end else begin
            st_d.skid_v = 1'b1;
            st_d.skid_d = in_data;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign in_ready = !st_q.skid_v;
   assign out_valid = st_q.head_v;
   assign out_data = st_q.head_d;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_buf_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("Buffered word changed while stalled.");
endmodule : dsf_buf2
`default_nettype wire

// [src/dsf_filter.sv]
`timescale 1ns/100ps
`default_nettype none
module dsf_filter (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic sample_valid,
   input wire logic [dsf_pkg::SAMPLE_W-1:0] sample_data,
   output logic sample_ready,
   input wire logic cfg_load,
   input wire logic [2:0] cfg_mode,
   input wire logic [4:0] cfg_med_len,
   input wire logic [8:0] cfg_avg_len,
   output logic result_valid,
   output logic [dsf_pkg::RES_W-1:0] result_data,
   input wire logic result_ready
);
   import dsf_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_RANK, S_AVG, S_DIV, S_PUSH} dsf_state_e_t;

   typedef struct packed {
      dsf_state_e_t state;
      logic in_ready;
      logic [2:0] mode;
      logic [4:0] cust_med;
      logic [8:0] cust_avg;
      logic [4:0] mlen;
      logic [8:0] alen;
      logic [MED_MAX-1:0][SAMPLE_W-1:0] win;
      logic [4:0] mfill;
      logic [4:0] cand;
      logic [SAMPLE_W-1:0] med;
      logic [8:0] afill;
      logic [7:0] wp;
      logic [SUM_W-1:0] sum;
      logic [8:0] divisor;
      logic [DIVD_W-1:0] quo;
      logic [9:0] rem;
      logic [5:0] step;
      logic [RES_W-1:0] res;
   } dsf_core_t;

   dsf_core_t st_q, st_d;
   logic [SAMPLE_W-1:0] avg_mem [0:AVG_MAX-1];
   logic [MED_MAX-1:0] lt_vec, eq_vec;
   logic [4:0] lt_cnt, eq_cnt, target, new_mlen;
   logic [8:0] new_alen;
   logic [SAMPLE_W-1:0] oldest;
   logic push_valid, push_ready, hit;
   logic [10:0] rem_sh;

   // ==========================================================
   // Window lengths from the current setting.
   always_comb begin
      new_mlen = MED_LEN_STD;
      new_alen = AVG_LEN_STD;
      case (st_q.mode)
         MODE_HIGH: begin
            new_mlen = MED_LEN_PRESET;
         end
         MODE_VHIGH: begin
            new_mlen = MED_LEN_PRESET;
            new_alen = AVG_LEN_VHIGH;
         end
         MODE_HIGHEST: begin
            new_mlen = MED_LEN_PRESET;
            new_alen = AVG_LEN_HIGHEST;
         end
         MODE_CUSTOM: begin
            new_mlen = st_q.cust_med;
            new_alen = st_q.cust_avg;
         end
         default: begin
            new_mlen = MED_LEN_STD;
         end
      endcase
   end

   // ==========================================================
   // Rank of the candidate against every live window entry.
   genvar gj;
   generate
      for (gj = 0; gj < MED_MAX; gj++) begin : g_rank
         assign lt_vec[gj] = (5'(gj) < st_q.mfill) && (st_q.win[gj] < st_q.win[st_q.cand]);
         assign eq_vec[gj] = (5'(gj) < st_q.mfill) && (st_q.win[gj] == st_q.win[st_q.cand]);
      end
   endgenerate

   always_comb begin
      lt_cnt = '0;
      eq_cnt = '0;
      for (int j = 0; j < MED_MAX; j++) begin
         lt_cnt = lt_cnt + 5'(lt_vec[j]);
         eq_cnt = eq_cnt + 5'(eq_vec[j]);
      end
   end

   // An even window picks the lower of the two middle values.
   assign target = 5'((st_q.mfill - 5'h01) >> 1);
   assign hit = (lt_cnt <= target) && ((lt_cnt + eq_cnt) > target);
   assign oldest = avg_mem[8'(st_q.wp - st_q.alen[7:0])];
   assign rem_sh = {st_q.rem, st_q.quo[DIVD_W-1]};
   assign push_valid = (st_q.state == S_PUSH);

   // ==========================================================
   // Sample sequencing.
   always_comb begin
      st_d = st_q;
      if (cfg_load && (cfg_mode <= MODE_CUSTOM)) begin
         st_d.mode = cfg_mode;
      end
      if (cfg_load) begin
         st_d.cust_med = (cfg_med_len == 5'h00) ? 5'h01 : ((cfg_med_len > MED_MAX_L) ? MED_MAX_L : cfg_med_len);
         st_d.cust_avg = (cfg_avg_len == 9'h000) ? 9'h001 : ((cfg_avg_len > AVG_MAX_L) ? AVG_MAX_L : cfg_avg_len);
      end
      case (st_q.state)
         S_IDLE: begin
            if (sample_valid && st_q.in_ready) begin
               st_d.in_ready = 1'b0;
               st_d.win = {st_q.win[MED_MAX-2:0], sample_data};
               st_d.cand = '0;
               st_d.mlen = new_mlen;
               st_d.alen = new_alen;
               // A new length restarts both windows so no stale sample leaks into them.
               if (new_mlen != st_q.mlen || new_alen != st_q.alen) begin
                  st_d.mfill = 5'h01;
                  st_d.afill = '0;
                  st_d.sum = '0;
               end else if (st_q.mfill < new_mlen) begin
                  st_d.mfill = st_q.mfill + 5'h01;
               end
               st_d.state = S_RANK;
            end
         end
         S_RANK: begin
            if (hit) begin
               st_d.med = st_q.win[st_q.cand];
               st_d.state = S_AVG;
            end else begin
               st_d.cand = st_q.cand + 5'h01;
            end
         end
         S_AVG: begin
            if (st_q.afill == st_q.alen) begin
               st_d.sum = st_q.sum + SUM_W'(st_q.med) - SUM_W'(oldest);
               st_d.divisor = st_q.afill;
               st_d.quo = {st_q.sum + SUM_W'(st_q.med) - SUM_W'(oldest), FRAC_W'(0)};
            end else begin
               st_d.sum = st_q.sum + SUM_W'(st_q.med);
               st_d.afill = st_q.afill + 9'h001;
               st_d.divisor = st_q.afill + 9'h001;
               st_d.quo = {st_q.sum + SUM_W'(st_q.med), FRAC_W'(0)};
            end
            st_d.wp = st_q.wp + 8'h01;
            st_d.rem = '0;
            st_d.step = '0;
            st_d.state = S_DIV;
         end
         S_DIV: begin
            // Restoring division, one quotient bit a cycle, keeps the datapath to one subtractor.
            if (rem_sh >= 11'(st_q.divisor)) begin
               st_d.rem = 10'(rem_sh - 11'(st_q.divisor));
               st_d.quo = {st_q.quo[DIVD_W-2:0], 1'b1};
            end else begin
               st_d.rem = rem_sh[9:0];
               st_d.quo = {st_q.quo[DIVD_W-2:0], 1'b0};
            end
            st_d.step = st_q.step + 6'h01;
            if (st_q.step == DIV_STEPS - 6'h01) begin
               st_d.res = st_d.quo[RES_W-1:0];
               st_d.state = S_PUSH;
            end
         end
         S_PUSH: begin
            if (push_ready) begin
               st_d.in_ready = 1'b1;
               st_d.state = S_IDLE;
            end
         end
         default: begin
            st_d.state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
         st_q.state <= S_IDLE;
         st_q.in_ready <= 1'b1;
         st_q.mode <= MODE_RESET;
         st_q.cust_med <= CUST_MED_RESET;
         st_q.cust_avg <= CUST_AVG_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // The history is memory, not reset: entries are only read once the fill count covers them.
   always_ff @(posedge sys_clk) begin
      if (st_q.state == S_AVG) begin
         avg_mem[st_q.wp] <= st_q.med;
      end
   end

   assign sample_ready = st_q.in_ready;

   dsf_buf2 #(.WIDTH(RES_W)) u_out_buf (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_valid(push_valid),
      .in_data(st_q.res),
      .in_ready(push_ready),
      .out_valid(result_valid),
      .out_data(result_data),
      .out_ready(result_ready)
   );

   // ==========================================================
   // Checks.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_one_result_each: assert property (sample_valid && sample_ready |-> ##[1:60] push_valid)
      else $error("No result followed an accepted sample.");
   a_no_second_take: assert property (sample_valid && sample_ready |=> !sample_ready until push_valid)
      else $error("Sample taken before the previous result left.");
   a_preset_lengths: assert property (st_q.state == S_IDLE && sample_valid && sample_ready
      && st_q.mode == MODE_HIGHEST |=> st_q.mlen == 5'h09 && st_q.alen == 9'h080)
      else $error("Highest preset lengths wrong.");
   a_high_lengths: assert property (st_q.state == S_IDLE && sample_valid && sample_ready
      && st_q.mode == MODE_HIGH |=> st_q.mlen == 5'h09 && st_q.alen == 9'h001)
      else $error("High preset lengths wrong.");
   a_custom_range: assert property (st_q.cust_med >= 5'h01 && st_q.cust_med <= 5'h15
      && st_q.cust_avg >= 9'h001 && st_q.cust_avg <= 9'h100)
      else $error("Custom length out of range.");
   a_mode_legal: assert property (st_q.mode <= MODE_CUSTOM)
      else $error("Illegal filter choice held.");
   a_reset_mode: assert property ($fell(reset) |-> st_q.mode == MODE_HIGHEST)
      else $error("Setting after reset is not highest.");
   a_window_fill: assert property (st_q.mfill <= st_q.mlen && st_q.afill <= st_q.alen)
      else $error("Window holds more than its length.");
   a_rank_bound: assert property (st_q.state == S_RANK |-> st_q.cand < st_q.mfill)
      else $error("Median search ran past the window.");
   a_pass_through: assert property (push_valid && st_q.mlen == 5'h01 && st_q.alen == 9'h001
      |-> st_q.res == {st_q.win[0], 8'h00})
      else $error("Length one did not pass the sample through.");
   a_single_mean: assert property (push_valid && st_q.afill == 9'h001 |-> st_q.res == {st_q.med, 8'h00})
      else $error("Mean of one value differs from it.");
   a_frac_kept: assert property (st_q.state == S_DIV && st_q.step == 6'h1f |=> st_q.res == 24'(
      ({$past(st_q.sum), 8'h00}) / 32'($past(st_q.divisor))))
      else $error("Mean lost fractional precision.");

   c_custom_push: cover property (push_valid && st_q.mode == MODE_CUSTOM);
   c_full_avg: cover property (push_valid && st_q.afill == 9'h080);
   c_out_stall: cover property (result_valid && !result_ready && !push_ready);
endmodule : dsf_filter
`default_nettype wire

// [src/dsf_pkg.sv]
package dsf_pkg;
   // ==========================================================
   // Data widths.
   localparam int SAMPLE_W = 16;
   localparam int FRAC_W = 8;
   localparam int RES_W = SAMPLE_W + FRAC_W;
   localparam int SUM_W = 24;
   localparam int DIVD_W = SUM_W + FRAC_W;
   // ==========================================================
   // Window limits.
   localparam int MED_MAX = 21;
   localparam int AVG_MAX = 256;
   localparam logic [4:0] MED_MAX_L = 5'h15;
   localparam logic [8:0] AVG_MAX_L = 9'h100;
   // ==========================================================
   // Filter choices and reset value.
   localparam logic [2:0] MODE_STANDARD = 3'h0;
   localparam logic [2:0] MODE_HIGH = 3'h1;
   localparam logic [2:0] MODE_VHIGH = 3'h2;
   localparam logic [2:0] MODE_HIGHEST = 3'h3;
   localparam logic [2:0] MODE_CUSTOM = 3'h4;
   localparam logic [2:0] MODE_RESET = MODE_HIGHEST;
   // ==========================================================
   // Preset window lengths.
   localparam logic [4:0] MED_LEN_STD = 5'h01;
   localparam logic [4:0] MED_LEN_PRESET = 5'h09;
   localparam logic [8:0] AVG_LEN_STD = 9'h001;
   localparam logic [8:0] AVG_LEN_VHIGH = 9'h010;
   localparam logic [8:0] AVG_LEN_HIGHEST = 9'h080;
   localparam logic [4:0] CUST_MED_RESET = 5'h01;
   localparam logic [8:0] CUST_AVG_RESET = 9'h001;
   // ==========================================================
   // Timing.
   localparam logic [5:0] DIV_STEPS = 6'h20;
   localparam int MAX_LATENCY = 60;
endpackage : dsf_pkg

// [tb/dsf_src_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Raw sample source: holds each word until taken, and idles for at least gap+1 cycles between words.
module dsf_src_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [3:0] gap,
   output logic sample_valid,
   output logic [dsf_pkg::SAMPLE_W-1:0] sample_data,
   input wire logic sample_ready
);
   import dsf_pkg::*;
   logic [SAMPLE_W-1:0] q[$];
   int idle;

   task automatic push(input logic [SAMPLE_W-1:0] d);
      q.push_back(d);
   endtask : push

   // Idle data toggles every cycle so a design that samples it outside a take is caught.
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sample_valid <= 1'b0;
         sample_data <= 16'h0000;
         idle <= 0;
      end else if (!sample_valid || sample_ready) begin
         if (sample_valid) begin
            sample_valid <= 1'b0;
            sample_data <= ~sample_data;
            idle <= gap;
         end else if (idle > 0) begin
            idle <= idle - 1;
            sample_data <= ~sample_data;
         end else if (q.size() > 0) begin
            sample_valid <= 1'b1;
            sample_data <= q.pop_front();
         end else begin
            sample_data <= ~sample_data;
         end
      end
   end
endmodule : dsf_src_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import dsf_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic sample_valid, sample_ready, result_valid;
   logic cfg_load = 1'b0;
   logic result_ready = 1'b0;
   logic [SAMPLE_W-1:0] sample_data;
   logic [2:0] cfg_mode = 3'h0;
   logic [4:0] cfg_med_len = 5'h00;
   logic [8:0] cfg_avg_len = 9'h000;
   logic [RES_W-1:0] result_data;
   logic [3:0] gap = 4'h0;
   logic stall_en = 1'b0;
   logic [31:0] rng = 32'h0000005e;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   int mode_i = 3, cus_med = 1, cus_avg = 1, cur_m = 0, cur_a = 0;
   int raw_w[$];
   int med_w[$];
   logic [RES_W-1:0] exp_q[$];
   int tm[7] = '{0, 1, 2, 5, 4, 4, 4};
   int tml[7] = '{0, 0, 0, 0, 0, 2, 31};
   int tal[7] = '{0, 0, 0, 0, 0, 3, 300};
   int tn[7] = '{6, 12, 20, 20, 6, 10, 270};

   always #20 sys_clk = ~sys_clk;

   dsf_filter uut (.sys_clk(sys_clk), .reset(reset), .sample_valid(sample_valid), .sample_data(sample_data),
      .sample_ready(sample_ready), .cfg_load(cfg_load), .cfg_mode(cfg_mode), .cfg_med_len(cfg_med_len),
      .cfg_avg_len(cfg_avg_len), .result_valid(result_valid), .result_data(result_data),
      .result_ready(result_ready));
   dsf_src_model src (.sys_clk(sys_clk), .reset(reset), .gap(gap), .sample_valid(sample_valid),
      .sample_data(sample_data), .sample_ready(sample_ready));

   // ==========================================================
   // Helpers.
   function automatic logic [31:0] xorshift();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xorshift

   task automatic check(input string name, input logic [RES_W-1:0] exp, input logic [RES_W-1:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         n_mismatch++;
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test

   // ==========================================================
   // Reference model: median of the raw window feeds the mean of the median window.
   task automatic add_sample(input logic [SAMPLE_W-1:0] d);
      int m, a;
      int srt[$];
      longint sum;
      m = (mode_i == 0) ? 1 : (mode_i == 4) ? cus_med : 9;
      a = (mode_i <= 1) ? 1 : (mode_i == 2) ? 16 : (mode_i == 3) ? 128 : cus_avg;
      if (m != cur_m || a != cur_a) begin
         raw_w.delete();
         med_w.delete();
      end
      cur_m = m;
      cur_a = a;
      raw_w.push_back(int'(d));
      if (raw_w.size() > m) void'(raw_w.pop_front());
      srt = raw_w;
      srt.sort();
      med_w.push_back(srt[(srt.size() - 1) / 2]);
      if (med_w.size() > a) void'(med_w.pop_front());
      sum = 0;
      foreach (med_w[i]) sum += med_w[i];
      sum = (sum * 256) / med_w.size();
      exp_q.push_back(sum[RES_W-1:0]);
      src.push(d);
   endtask : add_sample

   task automatic load(input int md, input int ml, input int al);
      @(posedge sys_clk);
      cfg_mode <= md[2:0];
      cfg_med_len <= ml[4:0];
      cfg_avg_len <= al[8:0];
      cfg_load <= 1'b1;
      @(posedge sys_clk);
      cfg_load <= 1'b0;
      if (md <= 4) mode_i = md;
      cus_med = (ml == 0) ? 1 : (ml > 21) ? 21 : ml;
      cus_avg = (al == 0) ? 1 : (al > 256) ? 256 : al;
   endtask : load

   // Config may only change once the pipeline is empty, so the model stays aligned.
   task automatic run(input int n);
      logic [31:0] r;
      repeat (n) begin
         r = xorshift();
         add_sample(r[15:0]);
      end
      while (exp_q.size() > 0) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
   endtask : run

   // ==========================================================
   // Sink with random stalls, result compare and timeout.
   always @(posedge sys_clk) begin
      logic [31:0] r;
      cycles++;
      if (!reset && result_valid === 1'b1 && result_ready) begin
         if (exp_q.size() == 0) begin
            total_checks++;
            n_mismatch++;
            $display("mismatch extra_result expected none seen %h", result_data);
         end else begin
            check("result_data", exp_q.pop_front(), result_data);
         end
      end
      r = xorshift();
      result_ready <= stall_en ? r[0] : 1'b1;
      if (cycles > 80000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      check("ready_in_reset", 24'h000001, {23'h0, sample_ready});
      check("valid_in_reset", 24'h000000, {23'h0, result_valid});
      reset <= 1'b0;
      run(140);
      stall_en <= 1'b1;
      gap <= 4'h3;
      for (int i = 0; i < 7; i++) begin
         load(tm[i], tml[i], tal[i]);
         run(tn[i]);
      end
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
